// >>> common/fpes_pkg.sv
// Package of register offsets, mode bits and constants for the flash program/erase sequencer
package fpes_pkg;
	localparam logic [15:0] ADDR_MODE_CTRL  = 16'hFF80;
	localparam logic [15:0] ADDR_BLK_SEL1   = 16'hFF82;
	localparam logic [15:0] ADDR_BLK_SEL2   = 16'hFF83;
	localparam logic [15:0] ADDR_FLASH_LAST = 16'hEF7F;
	localparam int          BIT_PROGRAM     = 0;
	localparam int          BIT_ERASE       = 1;
	localparam int          BIT_PROG_VERIFY = 2;
	localparam int          BIT_ERASE_VERIFY = 3;
	localparam int          BIT_VPP_PRESENT = 7;
	localparam logic [7:0]  RST_MODE_CTRL   = 8'h00;
	localparam logic [7:0]  RST_BLK_SEL     = 8'h00;
	localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
	localparam logic [7:0]  PROGRAMMED_BYTE = 8'h00;
	typedef enum logic [2:0] {
		FPES_IDLE,
		FPES_PROGRAM,
		FPES_ERASE,
		FPES_PROG_VERIFY,
		FPES_ERASE_VERIFY,
		FPES_PREWRITE_VERIFY
	} fpes_mode_t;
endpackage : fpes_pkg

// >>> hdl/fpes_sequencer.sv
// Flash program/erase sequencer: mode control, block select, address/data latches, verify read path
// Operation
// - Five modes: program, erase, program-verify, erase-verify, prewrite-verify; prewrite-verify is the program-verify bit with a latched zero byte.
// - Flash gives no read data while program or erase is active.
// - Write to flash in a selected block latches address and data unless program or erase is active.
// - In program-verify, flash reads return latched location under verify conditions.
// - In erase-verify a dummy FF write latches address; next read returns it.
`timescale 1ns/1ns
`default_nettype none
module fpes_sequencer #(
	parameter int ADDR_W  = 16,
	parameter int BLOCKS  = 16,
	parameter int BLOCK_W = 4
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Register and flash access port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [7:0]        wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [7:0]        rdata,
	// Programming voltage present on the programming voltage pin
	input  wire logic              programming_voltage_pin,
	// Flash array
	output logic      [ADDR_W-1:0] array_addr,
	input  wire logic [7:0]        array_rdata,
	output logic      [ADDR_W-1:0] latch_addr,
	output logic      [7:0]        latch_data,
	output logic      [BLOCKS-1:0] array_block_sel,
	output logic                   array_program,
	output logic                   array_erase,
	output logic                   array_prog_verify,
	output logic                   array_erase_verify,
	output logic                   array_prewrite_verify,
	output logic                   flash_busy
);
	// Refuse geometries that the block decode cannot serve
	generate
		if (ADDR_W != 16 || BLOCKS < 1 || BLOCKS > 16 || BLOCK_W < 1 || BLOCK_W > 8
			|| BLOCKS > (1 << BLOCK_W))
		begin : g_bad_param
			$error("fpes_sequencer: unsupported parameters");
		end
	endgenerate

	logic [3:0]        mode_r, mode_nxt;
	logic [7:0]        blk1_r, blk1_nxt;
	logic [7:0]        blk2_r, blk2_nxt;
	logic [ADDR_W-1:0] ladr_r, ladr_nxt;
	logic [7:0]        ldat_r, ldat_nxt;
	logic [7:0]        rdata_r, rdata_nxt;
	logic              prew_r, prew_nxt;
	logic [15:0]       blk_all;
	logic [BLOCKS-1:0] blk_hit;
	logic              in_flash, in_sel, vpp;
	logic              verify_mode;
	fpes_pkg::fpes_mode_t mode_now;

	assign vpp      = programming_voltage_pin;
	assign blk_all  = {blk2_r, blk1_r};
	assign in_flash = addr <= fpes_pkg::ADDR_FLASH_LAST;

	// Block decode: each select bit covers the address slice whose top BLOCK_W bits equal its index
	genvar g;
	generate
		for (g = 0; g < BLOCKS; g++)
		begin : g_blk
			assign blk_hit[g] = blk_all[g] && (addr[ADDR_W-1 -: BLOCK_W] == BLOCK_W'(g));
		end
	endgenerate
	assign in_sel = in_flash && (|blk_hit);

	always_comb
	begin
		mode_now = fpes_pkg::FPES_IDLE;
		if (mode_r[fpes_pkg::BIT_PROGRAM])
			mode_now = fpes_pkg::FPES_PROGRAM;
		else if (mode_r[fpes_pkg::BIT_ERASE])
			mode_now = fpes_pkg::FPES_ERASE;
		else if (mode_r[fpes_pkg::BIT_PROG_VERIFY] && prew_r)
			mode_now = fpes_pkg::FPES_PREWRITE_VERIFY;
		else if (mode_r[fpes_pkg::BIT_PROG_VERIFY])
			mode_now = fpes_pkg::FPES_PROG_VERIFY;
		else if (mode_r[fpes_pkg::BIT_ERASE_VERIFY])
			mode_now = fpes_pkg::FPES_ERASE_VERIFY;
	end

	assign verify_mode = mode_now == fpes_pkg::FPES_PROG_VERIFY || mode_now == fpes_pkg::FPES_ERASE_VERIFY
		|| mode_now == fpes_pkg::FPES_PREWRITE_VERIFY;

	// Strobe decode shared by the state groups
	logic              wr_mode;
	logic              wr_blk1;
	logic              wr_blk2;
	logic              wr_flash;
	logic              rd_mode;
	logic              rd_blk1;
	logic              rd_blk2;
	logic              rd_flash;
	logic              array_idle;

	assign wr_mode    = wr && (addr == fpes_pkg::ADDR_MODE_CTRL);
	assign wr_blk1    = wr && (addr == fpes_pkg::ADDR_BLK_SEL1);
	assign wr_blk2    = wr && (addr == fpes_pkg::ADDR_BLK_SEL2);
	assign array_idle = !mode_r[fpes_pkg::BIT_PROGRAM] && !mode_r[fpes_pkg::BIT_ERASE];

	// Flash writes land only in a selected block while no pulse runs
	assign wr_flash   = wr && in_sel && array_idle;

	assign rd_mode    = rd && (addr == fpes_pkg::ADDR_MODE_CTRL);
	assign rd_blk1    = rd && (addr == fpes_pkg::ADDR_BLK_SEL1);
	assign rd_blk2    = rd && (addr == fpes_pkg::ADDR_BLK_SEL2);

	// No array data while programming or erasing
	assign rd_flash   = rd && in_flash && !flash_busy;

	// Mode control: mode bits hold only while the programming voltage stands
	always_comb
	begin
		mode_nxt = mode_r;
		if (wr_mode)
		begin
			mode_nxt = wdata[3:0];
		end
		if (!vpp)
		begin
			mode_nxt = 4'h0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			mode_r <= fpes_pkg::RST_MODE_CTRL[3:0];
		end
		else
		begin
			mode_r <= mode_nxt;
		end
	end

	// Block select registers
	always_comb
	begin
		blk1_nxt = blk1_r;
		blk2_nxt = blk2_r;
		if (wr_blk1)
		begin
			blk1_nxt = wdata;
		end
		if (wr_blk2)
		begin
			blk2_nxt = wdata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			blk1_r <= fpes_pkg::RST_BLK_SEL;
			blk2_r <= fpes_pkg::RST_BLK_SEL;
		end
		else
		begin
			blk1_r <= blk1_nxt;
			blk2_r <= blk2_nxt;
		end
	end

	// Address and data latches; a zero byte marks the prewrite pass
	always_comb
	begin
		ladr_nxt = ladr_r;
		ldat_nxt = ldat_r;
		prew_nxt = prew_r;
		if (wr_flash)
		begin
			ladr_nxt = addr;
			ldat_nxt = wdata;
			prew_nxt = wdata == fpes_pkg::PROGRAMMED_BYTE;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ladr_r <= '0;
			ldat_r <= 8'h00;
			prew_r <= 1'b0;
		end
		else
		begin
			ladr_r <= ladr_nxt;
			ldat_r <= ldat_nxt;
			prew_r <= prew_nxt;
		end
	end

	// Read data stand for one cycle after the strobe, zero otherwise
	always_comb
	begin
		rdata_nxt = 8'h00;
		if (rd_mode)
		begin
			rdata_nxt = {vpp, 3'b000, mode_r};
		end
		else if (rd_blk1)
		begin
			rdata_nxt = blk1_r;
		end
		else if (rd_blk2)
		begin
			rdata_nxt = blk2_r;
		end
		else if (rd_flash)
		begin
			rdata_nxt = array_rdata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rdata_r <= 8'h00;
		end
		else
		begin
			rdata_r <= rdata_nxt;
		end
	end

	// In verify modes every flash read is steered to the latched location
	assign array_addr            = verify_mode ? ladr_r : addr;
	assign rdata                 = rdata_r;
	assign latch_addr            = ladr_r;
	assign latch_data            = ldat_r;
	assign array_block_sel       = blk_all[BLOCKS-1:0];
	assign array_program         = mode_now == fpes_pkg::FPES_PROGRAM;
	assign array_erase           = mode_now == fpes_pkg::FPES_ERASE;
	assign array_prog_verify     = mode_now == fpes_pkg::FPES_PROG_VERIFY;
	assign array_erase_verify    = mode_now == fpes_pkg::FPES_ERASE_VERIFY;
	assign array_prewrite_verify = mode_now == fpes_pkg::FPES_PREWRITE_VERIFY;
	assign flash_busy            = array_program || array_erase;
endmodule : fpes_sequencer
`default_nettype wire

// >>> bench/fpes_checker_assertions.sv
// Checker of the flash sequencer port behaviour
`timescale 1ns/1ns
`default_nettype none
module fpes_checker (
	// Clock, reset and access port
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [15:0] addr,
	input wire logic [7:0]  wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [7:0]  rdata,
	input wire logic        programming_voltage_pin,
	// Array side
	input wire logic [15:0] array_addr,
	input wire logic [15:0] latch_addr,
	input wire logic [7:0]  latch_data,
	input wire logic [15:0] array_block_sel,
	input wire logic        array_program,
	input wire logic        array_erase,
	input wire logic        array_prog_verify,
	input wire logic        array_erase_verify,
	input wire logic        flash_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_busy; flash_busy == (array_program | array_erase); endproperty
	a_busy: assert property (p_busy) else $error("busy flag wrong");
	property p_rdbusy; rd && flash_busy && addr <= 16'hEF7F |=> rdata == 8'h00; endproperty
	a_rdbusy: assert property (p_rdbusy) else $error("array read while busy");
	property p_mode; wr && addr == 16'hFF80 && wdata == 8'h01 && programming_voltage_pin |=> array_program; endproperty
	a_mode: assert property (p_mode) else $error("program bit not at bit 0");
	property p_one; $onehot0({array_program, array_erase, array_prog_verify, array_erase_verify}); endproperty
	a_one: assert property (p_one) else $error("two modes at once");
	property p_latch; wr && addr <= 16'hEF7F && !flash_busy && array_block_sel[addr[15:12]]
		|=> latch_addr == $past(addr) && latch_data == $past(wdata); endproperty
	a_latch: assert property (p_latch) else $error("latch not loaded");
	property p_pv; array_prog_verify |-> array_addr == latch_addr; endproperty
	a_pv: assert property (p_pv) else $error("verify address wrong");
	property p_ev; array_erase_verify |-> array_addr == latch_addr; endproperty
	a_ev: assert property (p_ev) else $error("erase verify address wrong");
	property p_refuse; wr && addr == 16'hFF80 && !programming_voltage_pin |=> !flash_busy; endproperty
	a_refuse: assert property (p_refuse) else $error("mode set without voltage");
endmodule : fpes_checker
bind fpes_sequencer fpes_checker fpes_checker_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata(rdata), .programming_voltage_pin(programming_voltage_pin), .array_addr(array_addr),
	.latch_addr(latch_addr), .latch_data(latch_data), .array_block_sel(array_block_sel),
	.array_program(array_program), .array_erase(array_erase), .array_prog_verify(array_prog_verify),
	.array_erase_verify(array_erase_verify), .flash_busy(flash_busy));
`default_nettype wire

// >>> bench/tb.sv
// Testbench of the flash sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, vpp = 1;
	logic [15:0] addr = 16'h0000, aa, la;
	logic [7:0] wdata = 8'h00, rdata, ld;
	logic [15:0] bs;
	logic p, e, pv, ev, pw, busy;
	int bad_count = 0, checks = 0;
	// Array content is a fixed function of its address
	wire logic [7:0] ard = aa[7:0] ^ 8'h5A;
	fpes_sequencer fpes_sequencer_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .programming_voltage_pin(vpp), .array_addr(aa), .array_rdata(ard), .latch_addr(la),
		.latch_data(ld), .array_block_sel(bs), .array_program(p), .array_erase(e), .array_prog_verify(pv),
		.array_erase_verify(ev), .array_prewrite_verify(pw), .flash_busy(busy));
	initial forever #50 clk = ~clk;
	task ck(input string n, input logic [15:0] x, input logic [15:0] g);
		checks++;
		if (g !== x)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask : ck
	task w(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
		@(negedge clk);
	endtask : w
	task r(input logic [15:0] a, input logic [7:0] x);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		@(negedge clk);
		ck("rdata", x, rdata);
	endtask : r
	task t_modes;
		for (int i = 0; i < 4; i++)
		begin
			w(16'hFF80, 8'h01 << i);
			ck("modes", 16'h1 << i, {ev, pv, e, p});
			r(16'hFF80, 8'h80 | (8'h01 << i));
		end
		w(16'hFF80, 8'h00);
		w(16'hFF83, 8'hA5);
		r(16'hFF83, 8'hA5);
		r(16'hFF81, 8'h00);
	endtask : t_modes
	task t_prog;
		w(16'hFF82, 8'h01);
		ck("blksel", 16'hA501, bs);
		w(16'h0123, 8'h3C);
		ck("latch", 16'h0123, la);
		ck("ldata", 16'h003C, ld);
		w(16'h1234, 8'h77);
		ck("latch", 16'h0123, la);
		w(16'hFF80, 8'h01);
		r(16'h0123, 8'h00);
		w(16'hFF80, 8'h04);
		repeat (40) @(posedge clk);
		r(16'h0500, 8'h79);
		w(16'h0124, 8'h00);
		ck("prewrite", 16'h1, pw);
	endtask : t_prog
	task t_erase;
		w(16'hFF80, 8'h02);
		r(16'h0200, 8'h00);
		w(16'hFF80, 8'h08);
		repeat (40) @(posedge clk);
		w(16'h0456, 8'hFF);
		repeat (20) @(posedge clk);
		r(16'h0999, 8'h0C);
		@(posedge clk);
		vpp <= 0;
		w(16'hFF80, 8'h01);
		ck("busy", 16'h0, busy);
		@(posedge clk);
		vpp <= 1;
	endtask : t_erase
	task results;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1;
		t_modes;
		t_prog;
		t_erase;
		results;
	end
endmodule : tb
`default_nettype wire
